// ### inc/tlal_pkg.sv
// Package for the temperature limit and alert core: register map, fields, reset values, timing.
// Assumes a 200 MHz single clock and an APB3 slave with 32-bit data.
package tlal_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam real         CONV_TIME_MS    = 31.25;
  localparam int unsigned CONV_CYCLES     = int'(CONV_TIME_MS * CLK_HZ / 1000.0);
  localparam int unsigned RATE_W          = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG      = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_RATE        = 8'h08;
  localparam logic [7:0] ADDR_MODE        = 8'h0C;
  localparam logic [7:0] ADDR_LOC_TEMP    = 8'h10;
  localparam logic [7:0] ADDR_REM_TEMP    = 8'h14;
  localparam logic [7:0] ADDR_LOC_HIGH    = 8'h18;
  localparam logic [7:0] ADDR_REM_HIGH    = 8'h1C;
  localparam logic [7:0] ADDR_REM_LOW     = 8'h20;
  localparam logic [7:0] ADDR_REM_CRIT    = 8'h24;
  localparam logic [7:0] ADDR_HYST        = 8'h28;
  localparam logic [7:0] ADDR_OFFSET      = 8'h2C;

  // Configuration fields
  localparam int unsigned CFG_ALERT_MASK  = 7;
  localparam int unsigned CFG_STANDBY     = 6;
  localparam int unsigned CFG_PIN_TACH    = 2;
  localparam int unsigned CFG_PWM_SBY_DIS = 5;
  localparam int unsigned CFG_W           = 8;
  localparam logic [7:0]  CFG_RESET       = 8'h00;

  // Mode fields
  localparam int unsigned MODE_COMPARATOR = 0;
  localparam int unsigned MODE_ARA_OFF    = 1;
  localparam logic [7:0]  MODE_RESET      = 8'h00;

  // Status fields
  localparam int unsigned ST_BUSY         = 7;
  localparam int unsigned ST_LOC_HIGH     = 6;
  localparam int unsigned ST_REM_HIGH     = 4;
  localparam int unsigned ST_REM_LOW      = 3;
  localparam int unsigned ST_OPEN         = 2;
  localparam int unsigned ST_REM_CRIT     = 1;
  localparam logic [7:0]  ST_ALERT_BITS   = 8'h5A;

  localparam logic [7:0]  LOC_HIGH_RESET  = 8'h46;
  localparam logic [15:0] REM_HIGH_RESET  = 16'h4600;
  localparam logic [15:0] REM_LOW_RESET   = 16'h0000;
  localparam logic [7:0]  REM_CRIT_RESET  = 8'h55;
  localparam logic [7:0]  HYST_RESET      = 8'h04;
  localparam logic [7:0]  RATE_RESET      = 8'h08;
  localparam logic [15:0] REM_RESULT_MASK = 16'hFFE0;

  typedef struct packed {
    logic        valid;
    logic [7:0]  local_temp;
    logic [15:0] remote_temp;
    logic        open_diode;
  } tlal_sample_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tlal_apb_rsp_t;

endpackage : tlal_pkg

// ### src/tlal_core.sv
// Temperature limit and alert core: conversion sequencing, offset, limits, status, alert pin.
// Assumes an APB3 master on the same clock and an analog front end that delivers one
// sample per conversion and holds it valid until the conversion time is up.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps

// Function
// - Conversion measures both, updates registers, 31.25ms
// - Lower rate inserts idle delay between conversions
// - Remote result is 11 bits left-justified
// - Local reading and limits are bytes
// - Remote reading adds signed offset pair
// - Compare readings against limits, set flags
// - Unmasked alert pulls low on non-busy/open flag
// - Mask zero enables, mask one suppresses alert
// - Pin-select zero makes pin the alert output
// - Comparator mode releases alert when condition clears
// - Interrupt-mode status read with flags sets mask
// - Interrupt-mode flags clear only on status read
// - Interrupt-mode status read clears flags, releases alert, masks
// - Standby stops continuous conversions
// - Bit 5 chooses PWM keep or disable in standby
// - Hysteresis from programmable register applies to limits
// - Alert-response address sent releases alert, sets mask
// - Mask and alert-response bits reset low
module tlal_core
  import tlal_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_CYCLES
)(
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output tlal_pkg::tlal_apb_rsp_t   apb_rsp,
  input  tlal_pkg::tlal_sample_t    sample,
  output logic                      conv_start,
  input  wire logic                 ara_addr_sent,
  output logic                      alert_oe_b,
  output logic                      tach_select,
  output logic                      pwm_enable,
  output logic                      busy
);
  import tlal_pkg::*;

  typedef enum logic [2:0] {
    TLAL_IDLE = 3'b001,
    TLAL_CONV = 3'b010,
    TLAL_WAIT = 3'b100
  } tlal_state_t;

  tlal_state_t   state, next_state;
  logic [31:0]   timer, next_timer;
  logic [3:0]    idle_left, next_idle_left;
  logic [7:0]    config_reg, next_config_reg;
  logic [7:0]    mode_reg, next_mode_reg;
  logic [7:0]    rate_reg, next_rate_reg;
  logic [7:0]    status, next_status;
  logic [7:0]    local_temp_reading, next_local_temp_reading;
  logic [15:0]   remote_temp_reading, next_remote_temp_reading;
  logic [7:0]    local_high_limit, next_local_high_limit;
  logic [15:0]   remote_high_limit, next_remote_high_limit;
  logic [15:0]   remote_low_limit, next_remote_low_limit;
  logic [7:0]    remote_critical_limit, next_remote_critical_limit;
  logic [7:0]    hysteresis_value, next_hysteresis_value;
  logic [15:0]   remote_offset, next_remote_offset;
  tlal_apb_rsp_t next_apb_rsp;
  logic          next_conv_start;
  logic          next_alert_oe_b;
  logic          wr, rd, conv_done;
  logic [15:0]   corrected;
  logic [15:0]   hyst16;
  logic [7:0]    cond;

  // A held access after pready must not act twice
  assign wr        = psel && penable && pwrite && !apb_rsp.pready;
  assign rd        = psel && penable && !pwrite && !apb_rsp.pready;
  // Early front-end strobes are ignored until the conversion time is up
  assign conv_done = (state == TLAL_CONV) && (timer >= CONV_CYC - 1) && sample.valid;
  assign hyst16    = {hysteresis_value, 8'h00};
  assign corrected = (sample.remote_temp + remote_offset) & REM_RESULT_MASK;

  // Live limit conditions, with hysteresis on the release side in comparator mode
  always_comb
  begin
    cond = 8'h00;
    cond[ST_LOC_HIGH] = $signed(local_temp_reading) > $signed(local_high_limit) ||
      (status[ST_LOC_HIGH] && $signed(local_temp_reading) >= $signed(local_high_limit - hysteresis_value));
    cond[ST_REM_HIGH] = $signed(remote_temp_reading) > $signed(remote_high_limit) ||
      (status[ST_REM_HIGH] && $signed(remote_temp_reading) >= $signed(remote_high_limit - hyst16));
    cond[ST_REM_LOW]  = $signed(remote_temp_reading) < $signed(remote_low_limit) ||
      (status[ST_REM_LOW] && $signed(remote_temp_reading) <= $signed(remote_low_limit + hyst16));
    cond[ST_REM_CRIT] = $signed(remote_temp_reading[15:8]) > $signed(remote_critical_limit) ||
      (status[ST_REM_CRIT] &&
       $signed(remote_temp_reading[15:8]) >= $signed(remote_critical_limit - hysteresis_value));
  end

  // Conversion sequencer
  always_comb
  begin
    next_state      = state;
    next_timer      = timer;
    next_idle_left  = idle_left;
    next_conv_start = 1'b0;
    unique case (state)
      TLAL_IDLE:
      begin
        if (!config_reg[CFG_STANDBY])
        begin
          next_state      = TLAL_CONV;
          next_timer      = 32'h0000_0000;
          next_conv_start = 1'b1;
        end
      end
      TLAL_CONV:
      begin
        next_timer = timer + 32'h0000_0001;
        if (timer >= CONV_CYC - 1 && sample.valid)
        begin
          next_state     = TLAL_WAIT;
          next_timer     = 32'h0000_0000;
          next_idle_left = (rate_reg[3:0] >= RATE_RESET[3:0]) ? 4'h0 :
                           RATE_RESET[3:0] - rate_reg[3:0];
        end
      end
      TLAL_WAIT:
      begin
        next_timer = timer + 32'h0000_0001;
        if (idle_left == 4'h0)
          next_state = TLAL_IDLE;
        else if (timer >= CONV_CYC - 1)
        begin
          next_timer     = 32'h0000_0000;
          next_idle_left = idle_left - 4'h1;
        end
      end
    endcase
  end

  // Registers, status flags and alert
  always_comb
  begin
    next_config_reg            = config_reg;
    next_mode_reg              = mode_reg;
    next_rate_reg              = rate_reg;
    next_status                = status;
    next_local_temp_reading    = local_temp_reading;
    next_remote_temp_reading   = remote_temp_reading;
    next_local_high_limit      = local_high_limit;
    next_remote_high_limit     = remote_high_limit;
    next_remote_low_limit      = remote_low_limit;
    next_remote_critical_limit = remote_critical_limit;
    next_hysteresis_value      = hysteresis_value;
    next_remote_offset         = remote_offset;
    next_apb_rsp               = '0;
    next_apb_rsp.pready        = psel && penable && !apb_rsp.pready;
    if (wr)
    begin
      unique case (paddr)
        ADDR_CONFIG:   next_config_reg            = pwdata[7:0];
        ADDR_RATE:     next_rate_reg              = pwdata[7:0];
        ADDR_MODE:     next_mode_reg              = pwdata[7:0];
        ADDR_LOC_HIGH: next_local_high_limit      = pwdata[7:0];
        ADDR_REM_HIGH: next_remote_high_limit     = pwdata[15:0] & REM_RESULT_MASK;
        ADDR_REM_LOW:  next_remote_low_limit      = pwdata[15:0] & REM_RESULT_MASK;
        ADDR_REM_CRIT: next_remote_critical_limit = pwdata[7:0];
        ADDR_HYST:     next_hysteresis_value      = pwdata[7:0];
        ADDR_OFFSET:   next_remote_offset         = pwdata[15:0] & REM_RESULT_MASK;
        default:       next_apb_rsp.pslverr       = 1'b1;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        ADDR_CONFIG:   next_apb_rsp.prdata = {24'h0, config_reg};
        ADDR_STATUS:   next_apb_rsp.prdata = {24'h0, status};
        ADDR_RATE:     next_apb_rsp.prdata = {24'h0, rate_reg};
        ADDR_MODE:     next_apb_rsp.prdata = {24'h0, mode_reg};
        ADDR_LOC_TEMP: next_apb_rsp.prdata = {24'h0, local_temp_reading};
        ADDR_REM_TEMP: next_apb_rsp.prdata = {16'h0, remote_temp_reading};
        ADDR_LOC_HIGH: next_apb_rsp.prdata = {24'h0, local_high_limit};
        ADDR_REM_HIGH: next_apb_rsp.prdata = {16'h0, remote_high_limit};
        ADDR_REM_LOW:  next_apb_rsp.prdata = {16'h0, remote_low_limit};
        ADDR_REM_CRIT: next_apb_rsp.prdata = {24'h0, remote_critical_limit};
        ADDR_HYST:     next_apb_rsp.prdata = {24'h0, hysteresis_value};
        ADDR_OFFSET:   next_apb_rsp.prdata = {16'h0, remote_offset};
        default:       next_apb_rsp.pslverr = 1'b1;
      endcase
    end
    // Status read: interrupt style clears flags and, if any alert flag was set, masks the alert
    if (rd && paddr == ADDR_STATUS && !mode_reg[MODE_COMPARATOR])
    begin
      next_status = status & ~ST_ALERT_BITS;
      if ((status & ST_ALERT_BITS) != 8'h00)
        next_config_reg[CFG_ALERT_MASK] = 1'b1;
    end
    if (ara_addr_sent && !mode_reg[MODE_ARA_OFF])
      next_config_reg[CFG_ALERT_MASK] = 1'b1;
    next_status[ST_BUSY] = (next_state == TLAL_CONV);
    if (conv_done)
    begin
      next_local_temp_reading  = sample.local_temp;
      next_remote_temp_reading = sample.open_diode ? 16'h7F00 : corrected;
      next_status[ST_OPEN]     = sample.open_diode;
    end
    // Comparator style follows live conditions; interrupt style only sets (set beats read-clear)
    if (mode_reg[MODE_COMPARATOR])
      next_status = (next_status & ~ST_ALERT_BITS) | cond;
    else if (conv_done)
      next_status = next_status | (cond & ST_ALERT_BITS);
    next_alert_oe_b = !((next_status & ST_ALERT_BITS) != 8'h00 &&
                        !next_config_reg[CFG_ALERT_MASK] &&
                        !next_config_reg[CFG_PIN_TACH]);
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state                 <= TLAL_IDLE;
      timer                 <= 32'h0000_0000;
      idle_left             <= 4'h0;
      config_reg            <= CFG_RESET;
      mode_reg              <= MODE_RESET;
      rate_reg              <= RATE_RESET;
      status                <= 8'h00;
      local_temp_reading    <= 8'h00;
      remote_temp_reading   <= 16'h0000;
      local_high_limit      <= LOC_HIGH_RESET;
      remote_high_limit     <= REM_HIGH_RESET;
      remote_low_limit      <= REM_LOW_RESET;
      remote_critical_limit <= REM_CRIT_RESET;
      hysteresis_value      <= HYST_RESET;
      remote_offset         <= 16'h0000;
      apb_rsp               <= '0;
      conv_start            <= 1'b0;
      alert_oe_b            <= 1'b1;
      tach_select           <= 1'b0;
      pwm_enable            <= 1'b1;
      busy                  <= 1'b0;
    end
    else
    begin
      state                 <= next_state;
      timer                 <= next_timer;
      idle_left             <= next_idle_left;
      config_reg            <= next_config_reg;
      mode_reg              <= next_mode_reg;
      rate_reg              <= next_rate_reg;
      status                <= next_status;
      local_temp_reading    <= next_local_temp_reading;
      remote_temp_reading   <= next_remote_temp_reading;
      local_high_limit      <= next_local_high_limit;
      remote_high_limit     <= next_remote_high_limit;
      remote_low_limit      <= next_remote_low_limit;
      remote_critical_limit <= next_remote_critical_limit;
      hysteresis_value      <= next_hysteresis_value;
      remote_offset         <= next_remote_offset;
      apb_rsp               <= next_apb_rsp;
      conv_start            <= next_conv_start;
      alert_oe_b            <= next_alert_oe_b;
      tach_select           <= next_config_reg[CFG_PIN_TACH];
      pwm_enable            <= !(next_config_reg[CFG_STANDBY] && next_config_reg[CFG_PWM_SBY_DIS]);
      busy                  <= next_state == TLAL_CONV;
    end
  end

endmodule : tlal_core

// ### verif/tb_temp_limit_alert_logic.sv
// Self-checking bench for tlal_core: APB master, front end model, alert pin checks.
// Assumes the bound checker and a shortened conversion count.
`timescale 1ns/10ps
module tb_temp_limit_alert_logic;
  import tlal_pkg::*;
  localparam int unsigned CC = 20;
  typedef struct packed {logic [31:0] d; logic e; logic rd;} tlal_note_t;
  logic          clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, ara = 0;
  logic [7:0]    paddr = 8'h00, lt = 8'h30;
  logic [31:0]   pwdata = 32'h0, r;
  logic [15:0]   rt;
  tlal_apb_rsp_t apb_rsp;
  tlal_sample_t  sample;
  logic          conv_start, alert_oe_b, tach_select, pwm_enable, busy;
  tlal_note_t    q[$], nt;
  int            error_cnt = 0, n_checks = 0, cyc = 0, seed = 32'h7504, t0, n;
  logic [7:0]    ad [4] = '{ADDR_LOC_HIGH, ADDR_REM_CRIT, ADDR_HYST, ADDR_REM_HIGH};
  logic [31:0]   dv [4] = '{32'h20, 32'h55, 32'h4, 32'h4600};
  initial forever #2.5 clock = ~clock;
  tlal_core #(.CONV_CYC(CC)) dut_u (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp), .sample(sample),
    .conv_start(conv_start), .ara_addr_sent(ara), .alert_oe_b(alert_oe_b), .tach_select(tach_select),
    .pwm_enable(pwm_enable), .busy(busy));
  tlal_fe_model fe_u (.clock(clock), .rst_b(rst_b), .busy(busy), .local_t(lt), .remote_t(rt),
    .sample(sample));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e, input logic er);
    q.push_back('{e, er, !w});
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (apb_rsp.pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done;
    @(posedge clock);
    while (busy !== 1'b1) @(posedge clock);
    while (busy !== 1'b0) @(posedge clock);
    t0 = cyc;
    repeat (4) @(posedge clock);
  endtask : wait_done
  // Result watcher: every bus answer settles the oldest note
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      stop_test();
    end
    if (apb_rsp.pready === 1'b1 && q.size() > 0)
    begin
      nt = q.pop_front();
      check(nt.rd ? apb_rsp.prdata : nt.d, nt.d);
      check({31'h0, apb_rsp.pslverr}, {31'h0, nt.e});
    end
  end
  initial
  begin
    rt = 16'h1900 | 16'($unsigned($random(seed)) & 32'h1F);
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    check({alert_oe_b, tach_select, pwm_enable}, 3'b101);
    apb(0, ADDR_CONFIG, 0, {24'h0, CFG_RESET}, 0);
    apb(0, ADDR_MODE, 0, {24'h0, MODE_RESET}, 0);
    apb(0, 8'h30, 0, 0, 1);
    apb(1, ADDR_STATUS, 32'hFF, 0, 1);
    // Standby while random limits stand, so no sticky flag comes from them
    apb(1, ADDR_CONFIG, 32'h40, 0, 0);
    repeat (2) @(posedge clock);
    while (busy !== 1'b0) @(posedge clock);
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      apb(1, ad[i], r, 0, 0);
      apb(0, ad[i], 0, (i < 3) ? {24'h0, r[7:0]} : {16'h0, r[15:0] & REM_RESULT_MASK}, 0);
      apb(1, ad[i], dv[i], 0, 0);
    end
    apb(1, ADDR_OFFSET, 32'h0100, 0, 0);
    apb(1, ADDR_RATE, 0, 0, 0);
    apb(1, ADDR_CONFIG, 0, 0, 0);
    wait_done();
    wait_done();
    check(alert_oe_b, 0);
    apb(0, ADDR_STATUS, 0, 32'h40, 0);
    repeat (2) @(posedge clock);
    check(alert_oe_b, 1);
    apb(0, ADDR_CONFIG, 0, 32'h80, 0);
    apb(0, ADDR_STATUS, 0, 0, 0);
    apb(0, ADDR_LOC_TEMP, 0, 32'h30, 0);
    apb(0, ADDR_REM_TEMP, 0, {16'h0, (rt + 16'h0100) & REM_RESULT_MASK}, 0);
    while (conv_start !== 1'b1) @(posedge clock);
    check(cyc - t0 >= 8 * CC, 1);
    apb(1, ADDR_CONFIG, 0, 0, 0);
    wait_done();
    check(alert_oe_b, 0);
    ara <= 1'b1;
    @(posedge clock);
    ara <= 1'b0;
    repeat (2) @(posedge clock);
    check(alert_oe_b, 1);
    apb(0, ADDR_CONFIG, 0, 32'h80, 0);
    wait_done();
    check(alert_oe_b, 1);
    apb(1, ADDR_MODE, 1, 0, 0);
    apb(1, ADDR_CONFIG, 0, 0, 0);
    wait_done();
    check(alert_oe_b, 0);
    lt <= 8'h1E;
    wait_done();
    check(alert_oe_b, 0);
    lt <= 8'h1B;
    wait_done();
    check(alert_oe_b, 1);
    apb(1, ADDR_CONFIG, 32'h60, 0, 0);
    repeat (2) @(posedge clock);
    check(pwm_enable, 0);
    while (busy !== 1'b0) @(posedge clock);
    n = 0;
    repeat (300) @(posedge clock) n += int'(conv_start);
    check(n, 0);
    apb(1, ADDR_CONFIG, 32'h04, 0, 0);
    repeat (2) @(posedge clock);
    check({tach_select, alert_oe_b}, 2'b11);
    stop_test();
  end
endmodule : tb_temp_limit_alert_logic

// ### verif/tlal_fe_model.sv
// Front end stand-in: answers each conversion with a held sample.
// Assumes busy marks the conversion window; data is scrambled outside it.
`timescale 1ns/10ps
module tlal_fe_model
  import tlal_pkg::*;
#(
  parameter int unsigned DLY = 3
)(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              busy,
  input  wire logic [7:0]        local_t,
  input  wire logic [15:0]       remote_t,
  output tlal_pkg::tlal_sample_t sample
);
  import tlal_pkg::*;
  int unsigned cnt;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      cnt <= 0;
      sample <= '0;
    end
    else if (busy && cnt >= DLY)
      sample <= '{1'b1, local_t, remote_t, 1'b0};
    else
    begin
      cnt <= busy ? cnt + 1 : 0;
      // Stale data flips so a late capture cannot look right
      sample <= '{1'b0, ~sample.local_temp, ~sample.remote_temp, ~sample.open_diode};
    end
endmodule : tlal_fe_model

// ### verif/tlal_monitor.sv
// Checker for the alert core: bus answer timing, conversion length, alert causes.
// Assumes it is bound onto tlal_core and sees only its ports.
`timescale 1ns/10ps
module tlal_monitor
  import tlal_pkg::*;
#(
  parameter int unsigned CONV_CYC = 20
)(
  input wire logic               clock,
  input wire logic               rst_b,
  input wire logic               psel,
  input wire logic               penable,
  input tlal_pkg::tlal_apb_rsp_t apb_rsp,
  input wire logic               conv_start,
  input wire logic               ara_addr_sent,
  input wire logic               alert_oe_b,
  input wire logic               tach_select,
  input wire logic               busy
);
  import tlal_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  int unsigned bcnt;
  logic [2:0]  ecnt;
  // Cycles since the last thing allowed to move the alert pin
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      bcnt <= 0;
      ecnt <= 3'h0;
    end
    else
    begin
      bcnt <= busy ? bcnt + 1 : 0;
      if ((psel && penable) || ara_addr_sent || $fell(busy))
        ecnt <= 3'h0;
      else if (ecnt != 3'h7)
        ecnt <= ecnt + 3'h1;
    end
  sequence s_access;
    psel && penable && !apb_rsp.pready;
  endsequence
  a_ready_wait:   assert property (s_access |=> apb_rsp.pready) else $error("late bus answer");
  a_ready_pulse:  assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready held");
  a_rsp_idle:     assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
    else $error("response outside ready");
  a_pin_alert:    assert property (!alert_oe_b |-> !tach_select) else $error("alert on tach pin");
  a_start_busy:   assert property (conv_start |-> ##[0:1] busy) else $error("start without busy");
  a_conv_time:    assert property ($fell(busy) |-> bcnt + 1 >= CONV_CYC) else $error("short conversion");
  a_alert_cause:  assert property ($changed(alert_oe_b) |-> ecnt <= 3'h4 || $fell(busy))
    else $error("alert moved alone");
  a_ara_release:  assert property (ara_addr_sent |=> alert_oe_b) else $error("alert held after ara");
endmodule : tlal_monitor

bind tlal_core tlal_monitor #(.CONV_CYC(CONV_CYC)) mon_u (.clock(clock), .rst_b(rst_b), .psel(psel),
  .penable(penable), .apb_rsp(apb_rsp), .conv_start(conv_start), .ara_addr_sent(ara_addr_sent),
  .alert_oe_b(alert_oe_b), .tach_select(tach_select), .busy(busy));
